// *** verilog/rtc_trim_pkg.sv ***
// Constants shared by the trim and supply monitor logic.
// Assumes a 50 MHz system clock and a 32.768 kHz timebase on a pin.
package rtc_trim_pkg;
	localparam int          CLK_PERIOD_NS    = 20;
	localparam int          TRIM_W           = 7;
	localparam int          SUB_W            = 16;
	localparam logic [15:0] TICKS_PER_SEC    = 16'h8000;
	localparam logic [4:0]  TRIM_PERIOD_LAST = 5'h13;
	localparam logic [7:0]  TRIM_NEG_BASE    = 8'h80;
	localparam logic [6:0]  TRIM_ORIGIN      = 7'h01;
	localparam logic [6:0]  GAIN_MIN         = 7'h02;
	localparam logic [6:0]  GAIN_MAX         = 7'h3F;
	localparam logic [6:0]  LOSS_MIN         = 7'h42;
	localparam int          SAMPLE_WINDOW_US = 7800;
	localparam int          SAMPLE_CYCLES    = SAMPLE_WINDOW_US * 1000 / CLK_PERIOD_NS;
	localparam int          HALT_TIMEOUT_US  = 100;
	localparam int          HALT_CYCLES      = HALT_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
	// Reset values
	localparam logic [6:0]  TRIM_RST         = 7'h00;
	localparam logic [10:0] CTRL_RST         = 11'h000;
	localparam logic [4:0]  FLAGS_RST        = 5'h01;
	// Control field positions
	localparam int CTRL_W                  = 11;
	localparam int CTL_SUPPLY_SEL          = 0;
	localparam int CTL_PERIODIC_SELECT_LO  = 1;
	localparam int CTL_PERIODIC_SELECT_MID = 2;
	localparam int CTL_PERIODIC_SELECT_HI  = 3;
	localparam int CTL_TEST                = 4;
	localparam int CTL_USER_BIT_A          = 5;
	localparam int CTL_USER_BIT_B          = 6;
	localparam int CTL_USER_BIT_C          = 7;
	localparam int CTL_MODE_24H            = 8;
	localparam int CTL_DAILY_ALARM_EN      = 9;
	localparam int CTL_WEEKLY_ALARM_EN     = 10;
	// Status flag positions
	localparam int FLAG_W        = 5;
	localparam int FLG_OSC_STOP  = 0;
	localparam int FLG_LOW_SUPPLY = 1;
	localparam int FLG_EVT_BASE  = 2;
	localparam int EVT_W         = 3;
	// Supply sampler states
	typedef enum logic [1:0] {
		SMP_IDLE   = 2'b00,
		SMP_WINDOW = 2'b01
	} smp_state_t;
endpackage

// *** verilog/pin_sync3.sv ***
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous inputs; output is a clean level in clk_i domain.
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	// Pins and clean levels
	input  wire logic [W-1:0] pin_i,
	output var  logic [W-1:0] level_o
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// Stage chain; s1 feeds only s2
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// A bit changes only when stages two and three agree
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			level_o <= '0;
		else
			level_o <= (s2 & ~(s2 ^ s3)) | (level_o & (s2 ^ s3));
	end
endmodule
`default_nettype wire

// *** verilog/supply_sampler.sv ***
// Duty-cycled supply comparator sampler.
// Assumes synchronised comparator levels and a one-cycle second pulse.
`timescale 1ns/1ns
`default_nettype none
module supply_sampler
	import rtc_trim_pkg::*;
#(
	parameter int WINDOW_CYCLES = SAMPLE_CYCLES
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic nrst_i,
	// Control
	input  wire logic second_i,
	input  wire logic hold_i,
	input  wire logic thr_sel_i,
	input  wire logic below_hi_i,
	input  wire logic below_lo_i,
	// Results
	output var  logic sample_en_o,
	output var  logic low_evt_o
);
	localparam int CW = $clog2(WINDOW_CYCLES + 1);
	smp_state_t    state;
	logic [CW-1:0] win_cnt;
	logic          below_sel;

	// Threshold select: 0 is the higher level
	assign below_sel = thr_sel_i ? below_lo_i : below_hi_i;

	// Window once per second, suspended while the flag holds
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state   <= SMP_IDLE;
			win_cnt <= '0;
		end else begin
			case (state)
				SMP_IDLE: begin
					win_cnt <= '0;
					if (second_i && !hold_i)
						state <= SMP_WINDOW;
				end
				SMP_WINDOW: begin
					// Counter returns to zero on exit so it never passes the limit
					if (hold_i || win_cnt == CW'(WINDOW_CYCLES - 1)) begin
						state   <= SMP_IDLE;
						win_cnt <= '0;
					end else begin
						win_cnt <= CW'(win_cnt + 1'b1);
					end
				end
				default: state <= SMP_IDLE;
			endcase
		end
	end

	// Enable and detection pulse
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sample_en_o <= 1'b0;
			low_evt_o   <= 1'b0;
		end else begin
			sample_en_o <= (state == SMP_WINDOW) && !hold_i;
			low_evt_o   <= sample_en_o && !hold_i && below_sel;
		end
	end

	property p_hold_stops;
		@(posedge clk_i) disable iff (!nrst_i)
		hold_i |=> !sample_en_o;
	endproperty
	a_hold_stops: assert property (p_hold_stops)
		else $error("sampling while low supply flag held");

	property p_window_len;
		@(posedge clk_i) disable iff (!nrst_i)
		win_cnt < CW'(WINDOW_CYCLES);
	endproperty
	a_window_len: assert property (p_window_len)
		else $error("sample window overran");

	property p_thr_cause;
		@(posedge clk_i) disable iff (!nrst_i)
		low_evt_o |-> $past(sample_en_o && (thr_sel_i ? below_lo_i : below_hi_i));
	endproperty
	a_thr_cause: assert property (p_thr_cause)
		else $error("low supply event without selected comparator");
endmodule
`default_nettype wire

// *** verilog/rtc_trim_monitor.sv ***
// Timekeeping trim, oscillation halt detection and supply flags.
// Assumes host register writes arrive as one-cycle strobes on clk_i
// and the 32.768 kHz timebase and comparators arrive as raw pins.
`timescale 1ns/1ns
`default_nettype none

module rtc_trim_monitor
	import rtc_trim_pkg::*;
#(
	parameter int SEC_TICKS    = TICKS_PER_SEC,
	parameter int HALT_LIMIT   = HALT_CYCLES,
	parameter int SAMPLE_LIMIT = SAMPLE_CYCLES
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              nrst_i,
	// Timebase and comparator pins
	input  wire logic              osc_clk_i,
	input  wire logic              below_hi_thr_i,
	input  wire logic              below_lo_thr_i,
	// Trim register write
	input  wire logic              trim_wr_i,
	input  wire logic [TRIM_W-1:0] trim_data_i,
	// Control register write
	input  wire logic              ctrl_wr_i,
	input  wire logic [CTRL_W-1:0] ctrl_data_i,
	// Flag clears and interrupt events
	input  wire logic [FLAG_W-1:0] flag_clr_i,
	input  wire logic [EVT_W-1:0]  irq_evt_i,
	// Register contents
	output var  logic [TRIM_W-1:0] oscillation_trim_o,
	output var  logic [CTRL_W-1:0] ctrl_o,
	output var  logic [FLAG_W-1:0] status_flags_o,
	// Timing outputs
	output var  logic              second_tick_o,
	output var  logic              raw_clock_out_o,
	output logic                   sample_enable_o
);
	localparam int HW = $clog2(HALT_LIMIT + 1);
	// Nominal second; must exceed the largest loss correction of 124 counts
	localparam logic [SUB_W-1:0] SEC_LEN = SUB_W'(SEC_TICKS);

	logic [2:0]       pins_clean;
	logic             tb_level;
	logic             tb_prev;
	logic             tb_edge;
	logic [HW-1:0]    halt_cnt;
	logic             halt_evt;
	logic             low_evt;
	logic [6:0]       steps;
	logic             loss_mode;
	logic [SUB_W-1:0] corr;
	logic [SUB_W-1:0] sec_limit;
	logic [SUB_W-1:0] sub_cnt;
	logic [4:0]       trim_sec;

	// Steps from the trim code; dead codes give zero
	function automatic logic [6:0] trim_steps(input logic [6:0] c);
		logic [6:0] r;
		r = 7'h00;
		if (c >= GAIN_MIN && c <= GAIN_MAX)
			r = c - TRIM_ORIGIN;
		else if (c >= LOSS_MIN)
			r = 7'(TRIM_NEG_BASE - {1'b0, c});
		return r;
	endfunction

	// Pins into the clock domain
	pin_sync3 #(
		.W(3)
	) u_sync (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.pin_i  ({below_lo_thr_i, below_hi_thr_i, osc_clk_i}),
		.level_o(pins_clean)
	);

	assign tb_level = pins_clean[0];
	assign tb_edge  = tb_level && !tb_prev;

	// Edge history and untouched raw clock out
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tb_prev         <= 1'b0;
			raw_clock_out_o <= 1'b0;
		end else begin
			tb_prev         <= tb_level;
			raw_clock_out_o <= tb_level;
		end
	end

	// Halt watchdog: fires once when edges stop
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			halt_cnt <= '0;
		else if (tb_edge)
			halt_cnt <= '0;
		else if (halt_cnt != HW'(HALT_LIMIT))
			halt_cnt <= HW'(halt_cnt + 1'b1);
	end

	assign halt_evt = !tb_edge && halt_cnt == HW'(HALT_LIMIT - 1);

	// Trim correction, two counts per step per 20 s
	assign steps     = trim_steps(oscillation_trim_o);
	assign loss_mode = oscillation_trim_o >= LOSS_MIN;
	assign corr      = SUB_W'({steps, 1'b0});

	// Length of the current second in timebase counts
	always_comb begin
		sec_limit = SEC_LEN;
		if (trim_sec == 5'h00) begin
			if (loss_mode)
				sec_limit = SEC_LEN - corr;
			else
				sec_limit = SEC_LEN + corr;
		end
	end

	// Second divider and 20 s trim period
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sub_cnt       <= '0;
			trim_sec      <= '0;
			second_tick_o <= 1'b0;
		end else begin
			second_tick_o <= 1'b0;
			if (tb_edge) begin
				if (sub_cnt >= SUB_W'(sec_limit - 1'b1)) begin
					sub_cnt       <= '0;
					second_tick_o <= 1'b1;
					if (trim_sec == TRIM_PERIOD_LAST)
						trim_sec <= '0;
					else
						trim_sec <= 5'(trim_sec + 1'b1);
				end else begin
					sub_cnt <= SUB_W'(sub_cnt + 1'b1);
				end
			end
		end
	end

	// Trim register; a halt clears it
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			oscillation_trim_o <= TRIM_RST;
		else if (halt_evt)
			oscillation_trim_o <= TRIM_RST;
		else if (trim_wr_i)
			oscillation_trim_o <= trim_data_i;
	end

	// Control bits; a halt clears them
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			ctrl_o <= CTRL_RST;
		else if (halt_evt)
			ctrl_o <= CTRL_RST;
		else if (ctrl_wr_i)
			ctrl_o <= ctrl_data_i;
	end

	// Oscillation stop flag: set at power-up, set wins
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			status_flags_o[FLG_OSC_STOP] <= FLAGS_RST[FLG_OSC_STOP];
		else if (halt_evt)
			status_flags_o[FLG_OSC_STOP] <= 1'b1;
		else if (flag_clr_i[FLG_OSC_STOP])
			status_flags_o[FLG_OSC_STOP] <= 1'b0;
	end

	// Low supply flag: halt forces zero, then set wins
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			status_flags_o[FLG_LOW_SUPPLY] <= FLAGS_RST[FLG_LOW_SUPPLY];
		else if (halt_evt)
			status_flags_o[FLG_LOW_SUPPLY] <= 1'b0;
		else if (low_evt)
			status_flags_o[FLG_LOW_SUPPLY] <= 1'b1;
		else if (flag_clr_i[FLG_LOW_SUPPLY])
			status_flags_o[FLG_LOW_SUPPLY] <= 1'b0;
	end

	// Interrupt event flags, one per source
	for (genvar i = 0; i < EVT_W; i++) begin : g_evt
		always_ff @(posedge clk_i or negedge nrst_i) begin
			if (!nrst_i)
				status_flags_o[FLG_EVT_BASE+i] <= FLAGS_RST[FLG_EVT_BASE+i];
			else if (halt_evt)
				status_flags_o[FLG_EVT_BASE+i] <= 1'b0;
			else if (irq_evt_i[i])
				status_flags_o[FLG_EVT_BASE+i] <= 1'b1;
			else if (flag_clr_i[FLG_EVT_BASE+i])
				status_flags_o[FLG_EVT_BASE+i] <= 1'b0;
		end
	end

	// Duty-cycled supply check
	supply_sampler #(
		.WINDOW_CYCLES(SAMPLE_LIMIT)
	) u_sampler (
		.clk_i      (clk_i),
		.nrst_i     (nrst_i),
		.second_i   (second_tick_o),
		.hold_i     (status_flags_o[FLG_LOW_SUPPLY]),
		.thr_sel_i  (ctrl_o[CTL_SUPPLY_SEL]),
		.below_hi_i (pins_clean[1]),
		.below_lo_i (pins_clean[2]),
		.sample_en_o(sample_enable_o),
		.low_evt_o  (low_evt)
	);

	property p_halt_clears_low;
		@(posedge clk_i) disable iff (!nrst_i)
		halt_evt |=> status_flags_o[FLG_OSC_STOP] && !status_flags_o[FLG_LOW_SUPPLY];
	endproperty
	a_halt_clears_low: assert property (p_halt_clears_low)
		else $error("low supply flag survived oscillation stop");

	property p_halt_clears_all;
		@(posedge clk_i) disable iff (!nrst_i)
		halt_evt |=> oscillation_trim_o == TRIM_RST && ctrl_o == CTRL_RST
			&& status_flags_o[FLAG_W-1:FLG_EVT_BASE] == '0;
	endproperty
	a_halt_clears_all: assert property (p_halt_clears_all)
		else $error("register bits not cleared by oscillation stop");

	property p_stop_sticky;
		@(posedge clk_i) disable iff (!nrst_i)
		status_flags_o[FLG_OSC_STOP] && !flag_clr_i[FLG_OSC_STOP]
			|=> status_flags_o[FLG_OSC_STOP];
	endproperty
	a_stop_sticky: assert property (p_stop_sticky)
		else $error("oscillation stop flag dropped without clear");

	property p_low_sticky;
		@(posedge clk_i) disable iff (!nrst_i)
		status_flags_o[FLG_LOW_SUPPLY] && !flag_clr_i[FLG_LOW_SUPPLY] && !halt_evt
			|=> status_flags_o[FLG_LOW_SUPPLY];
	endproperty
	a_low_sticky: assert property (p_low_sticky)
		else $error("low supply flag dropped without clear");

	property p_power_up;
		@(posedge clk_i) $rose(nrst_i) |-> status_flags_o[FLG_OSC_STOP];
	endproperty
	a_power_up: assert property (p_power_up)
		else $error("oscillation stop flag not set after reset");

	property p_dead_codes;
		@(posedge clk_i) disable iff (!nrst_i)
		(oscillation_trim_o < GAIN_MIN || (oscillation_trim_o > GAIN_MAX
			&& oscillation_trim_o < LOSS_MIN)) |-> sec_limit == SEC_LEN;
	endproperty
	a_dead_codes: assert property (p_dead_codes)
		else $error("no-correction code changed the second length");

	property p_gain_len;
		@(posedge clk_i) disable iff (!nrst_i)
		trim_sec == 5'h00 && oscillation_trim_o >= GAIN_MIN && oscillation_trim_o <= GAIN_MAX
			|-> sec_limit == SEC_LEN + 16'({oscillation_trim_o - TRIM_ORIGIN, 1'b0});
	endproperty
	a_gain_len: assert property (p_gain_len)
		else $error("gain correction length wrong");

	property p_loss_len;
		@(posedge clk_i) disable iff (!nrst_i)
		trim_sec == 5'h00 && oscillation_trim_o >= LOSS_MIN
			|-> sec_limit == SEC_LEN - 16'({7'(8'h80 - {1'b0, oscillation_trim_o}), 1'b0});
	endproperty
	a_loss_len: assert property (p_loss_len)
		else $error("loss correction length wrong");

	property p_once_per_period;
		@(posedge clk_i) disable iff (!nrst_i)
		trim_sec != 5'h00 |-> sec_limit == SEC_LEN;
	endproperty
	a_once_per_period: assert property (p_once_per_period)
		else $error("correction outside first second of period");

	property p_raw_follows;
		@(posedge clk_i) disable iff (!nrst_i)
		tb_edge |=> raw_clock_out_o;
	endproperty
	a_raw_follows: assert property (p_raw_follows)
		else $error("raw clock output does not follow timebase");

	property p_raw_untrimmed;
		@(posedge clk_i) disable iff (!nrst_i)
		raw_clock_out_o == $past(tb_level);
	endproperty
	a_raw_untrimmed: assert property (p_raw_untrimmed)
		else $error("raw clock output altered");

	property p_trim_write;
		@(posedge clk_i) disable iff (!nrst_i)
		trim_wr_i && !halt_evt |=> oscillation_trim_o == $past(trim_data_i);
	endproperty
	a_trim_write: assert property (p_trim_write)
		else $error("trim write not held");

	property p_ctrl_write;
		@(posedge clk_i) disable iff (!nrst_i)
		ctrl_wr_i && !halt_evt |=> ctrl_o == $past(ctrl_data_i);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("control write not held");

	property p_low_set;
		@(posedge clk_i) disable iff (!nrst_i)
		low_evt && !halt_evt |=> status_flags_o[FLG_LOW_SUPPLY];
	endproperty
	a_low_set: assert property (p_low_set)
		else $error("low supply event not recorded");

	property p_tick_single;
		@(posedge clk_i) disable iff (!nrst_i)
		second_tick_o |=> !second_tick_o;
	endproperty
	a_tick_single: assert property (p_tick_single)
		else $error("second tick longer than one cycle");
endmodule
`default_nettype wire

// *** testbench/osc_model.sv ***
// Behavioural crystal timebase that drives the timebase pin.
// Assumes the bench gates it with run_i; a halted crystal rests low.
`timescale 1ns/1ns
`default_nettype none
module osc_model #(
	parameter int HALF_NS = 60
) (
	// Control
	input  wire logic run_i,
	// Timebase pin
	output var  logic osc_o
);
	// Toggle while running, park low once halted
	initial begin
		osc_o = 1'b0;
		forever begin
			#(HALF_NS);
			osc_o = run_i ? ~osc_o : 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** testbench/tb_rtc_trim_monitor.sv ***
// Self-checking bench for the trim and supply monitor block.
// Assumes a fast timebase model and a short second set by parameter.
`timescale 1ns/1ns
`default_nettype none
module tb_rtc_trim_monitor;
	import rtc_trim_pkg::*;
	localparam int HL = 40;
	localparam int ST = 200;
	localparam int SL = 20;
	localparam int EDGE_CYC = 6;
	logic        clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        osc_run = 1'b1;
	logic        osc_clk;
	logic        below_hi = 1'b0;
	logic        below_lo = 1'b0;
	logic        trim_wr = 1'b0;
	logic [6:0]  trim_data = 7'h00;
	logic        ctrl_wr = 1'b0;
	logic [10:0] ctrl_data = 11'h000;
	logic [4:0]  flag_clr = 5'h00;
	logic [2:0]  irq_evt = 3'h0;
	logic [6:0]  trim_q;
	logic [10:0] ctrl_q;
	logic [4:0]  flags;
	logic        tick;
	logic        raw_clk;
	logic        smp_en;
	int          fails = 0;
	int          checked = 0;
	int          n;
	int          i;
	int          j;
	int          ticks = 0;
	logic [6:0]  codes [10] = '{7'h00, 7'h01, 7'h40, 7'h41, 7'h02, 7'h3F, 7'h7F, 7'h42,
	                            7'h57, 7'h09};

	// System clock, 50 MHz
	always #10 clk_i = ~clk_i;

	osc_model #(.HALF_NS(EDGE_CYC * CLK_PERIOD_NS / 2)) u_osc (.run_i(osc_run), .osc_o(osc_clk));

	// Count ticks; a tick seen at a falling edge is counted at the next rise
	always @(posedge clk_i) begin
		if (tick === 1'b1)
			ticks <= ticks + 1;
	end

	rtc_trim_monitor #(.HALT_LIMIT(HL), .SAMPLE_LIMIT(SL), .SEC_TICKS(ST)) dut (
		.clk_i             (clk_i),
		.nrst_i            (nrst_i),
		.osc_clk_i         (osc_clk),
		.below_hi_thr_i    (below_hi),
		.below_lo_thr_i    (below_lo),
		.trim_wr_i         (trim_wr),
		.trim_data_i       (trim_data),
		.ctrl_wr_i         (ctrl_wr),
		.ctrl_data_i       (ctrl_data),
		.flag_clr_i        (flag_clr),
		.irq_evt_i         (irq_evt),
		.oscillation_trim_o(trim_q),
		.ctrl_o            (ctrl_q),
		.status_flags_o    (flags),
		.second_tick_o     (tick),
		.raw_clock_out_o   (raw_clk),
		.sample_enable_o   (smp_en)
	);

	// Verdict and end of run
	task automatic end_of_test;
		$display("Counts: checked %0d, fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Value compare, four-state exact
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Bounded wait for raw clock level; a hang ends the run
	task automatic wait_raw(input logic lvl);
		int k;
		for (k = 0; k < 40 && raw_clk !== lvl; k++) @(negedge clk_i);
		if (k == 40) begin
			fails++;
			$display("MISMATCH %0t raw clock stuck", $time);
			end_of_test();
		end
	endtask

	// Register write strobe: t=1 trim, t=0 control
	task automatic wr(input logic t, input logic [10:0] d);
		@(negedge clk_i);
		trim_wr = t;
		ctrl_wr = ~t;
		trim_data = d[6:0];
		ctrl_data = d;
		@(negedge clk_i);
		trim_wr = 1'b0;
		ctrl_wr = 1'b0;
	endtask

	// One-cycle flag clear and event strobes
	task automatic pulse(input logic [4:0] clr, input logic [2:0] evt);
		@(negedge clk_i);
		flag_clr = clr;
		irq_evt = evt;
		@(negedge clk_i);
		flag_clr = 5'h00;
		irq_evt = 3'h0;
	endtask

	// Rising edges of raw clock over 120 cycles, from an edge
	task automatic count_raw(output int cnt);
		logic prev;
		cnt = 0;
		wait_raw(1'b0);
		wait_raw(1'b1);
		prev = 1'b1;
		repeat (120) begin
			@(negedge clk_i);
			if (prev === 1'b0 && raw_clk === 1'b1) cnt++;
			prev = raw_clk;
		end
	endtask

	// Bounded wait for the next tick; len counts clocks since the call
	task automatic wait_tick(output int len);
		@(negedge clk_i);
		for (len = 1; len < 1500 && tick !== 1'b1; len++) @(negedge clk_i);
		if (tick !== 1'b1) begin
			fails++;
			$display("MISMATCH %0t second tick missing", $time);
			end_of_test();
		end
	endtask

	// Sampling cycles seen in the 40 clocks after a tick
	task automatic count_en(output int cnt);
		cnt = 0;
		repeat (40) begin
			@(negedge clk_i);
			if (smp_en === 1'b1) cnt++;
		end
	endtask

	// Main sequence
	initial begin
		repeat (20) @(negedge clk_i);
		nrst_i = 1'b1;
		@(negedge clk_i);
		chk(16'(flags), 16'h0001, "flags after power-up");
		chk(16'(trim_q), 16'h0000, "trim after power-up");
		chk(16'(ctrl_q), 16'h0000, "ctrl after power-up");
		chk(16'({tick, smp_en}), 16'h0000, "timing outputs idle");
		$display("Test reset done");

		for (i = 0; i < 10; i++) begin
			wr(1'b1, 11'(codes[i]));
			chk(16'(trim_q), 16'(codes[i]), "trim code");
		end
		wr(1'b1, 11'h080 - 11'd41);
		chk(16'(trim_q), 16'h0057, "minus 41 code");
		for (i = 0; i < 3; i++) begin
			wr(1'b1, 11'(codes[i * 3 + 1]));
			count_raw(n);
			chk(16'(n), 16'h0014, "raw clock edges");
		end
		wr(1'b0, 11'h555);
		chk(16'(ctrl_q), 16'h0555, "ctrl write");
		$display("Test trim and raw clock done");

		pulse(5'h01, 3'h0);
		chk(16'(flags), 16'h0000, "stop flag cleared");
		for (i = 0; i < 3; i++) begin
			pulse(5'h00, 3'(1 << i));
			repeat (5) @(negedge clk_i);
			chk(16'(flags), 16'(4 << i), "event flag sticky");
			pulse(5'(4 << i), 3'(1 << i));
			chk(16'(flags), 16'(4 << i), "set beats clear");
			pulse(5'(4 << i), 3'h0);
			chk(16'(flags), 16'h0000, "event flag cleared");
		end
		$display("Test flags done");

		wr(1'b1, 11'h055);
		wr(1'b0, 11'h7FF);
		pulse(5'h00, 3'h7);
		osc_run = 1'b0;
		for (n = 0; n < HL + 20 && flags[0] !== 1'b1; n++) @(negedge clk_i);
		if (n == HL + 20) begin
			fails++;
			$display("MISMATCH %0t halt never detected", $time);
			end_of_test();
		end
		chk(16'(n >= HL - 8 && n <= HL + 12), 16'h0001, "halt delay");
		chk(16'(flags), 16'h0001, "flags after halt");
		chk(16'(trim_q), 16'h0000, "trim after halt");
		chk(16'(ctrl_q), 16'h0000, "ctrl after halt");
		osc_run = 1'b1;
		repeat (30) @(negedge clk_i);
		chk(16'(flags), 16'h0001, "stop flag sticky");
		pulse(5'h01, 3'h0);
		chk(16'(flags), 16'h0000, "stop flag cleared");
		wr(1'b1, 11'h000);
		chk(16'(trim_q), 16'h0000, "no-correction code");
		$display("Test halt done");

		wait_tick(n);
		wait_tick(n);
		chk(16'(n), 16'(EDGE_CYC * ST), "plain second");
		count_en(n);
		chk(16'(n), 16'(SL), "sample window length");
		chk(16'({flags[1], smp_en}), 16'h0000, "no sampling off window");
		below_hi = 1'b1;
		wait_tick(n);
		count_en(n);
		chk(16'(flags), 16'h0002, "low supply at upper threshold");
		wait_tick(n);
		count_en(n);
		chk(16'(n), 16'h0000, "sampling held");
		pulse(5'h02, 3'h0);
		chk(16'(flags), 16'h0000, "low supply cleared");
		wr(1'b0, 11'h001);
		wait_tick(n);
		count_en(n);
		chk(16'(flags), 16'h0000, "above lower threshold");
		below_lo = 1'b1;
		wait_tick(n);
		count_en(n);
		chk(16'(flags), 16'h0002, "below lower threshold");
		below_hi = 1'b0;
		below_lo = 1'b0;
		pulse(5'h02, 3'h0);
		$display("Test supply done");

		wr(1'b1, 11'h009);
		for (j = 0; j < 25 && ticks != 19; j++) wait_tick(n);
		wait_tick(n);
		chk(16'(n), 16'(EDGE_CYC * (ST + 2 * (9 - 1))), "gain second");
		wait_tick(n);
		chk(16'(n), 16'(EDGE_CYC * ST), "uncorrected second");
		wr(1'b1, 11'h057);
		for (j = 0; j < 25 && ticks != 39; j++) wait_tick(n);
		wait_tick(n);
		chk(16'(n), 16'(EDGE_CYC * (ST - 2 * (128 - 8'h57))), "loss second");
		$display("Test trim seconds done");
		end_of_test();
	end
endmodule
`default_nettype wire
